// file: rtl/tlbc_pkg.sv
package tlbc_pkg;

  localparam int DW = 20;
  localparam int PW = 16;
  localparam int AW = 8;

  localparam logic [AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [AW-1:0] ALIGN_OFS  = 8'h04;
  localparam logic [AW-1:0] STATUS_OFS = 8'h08;
  localparam logic [AW-1:0] ERRCNT_OFS = 8'h0C;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SUB_LSB  = 2;
  localparam int CTRL_DBL_BIT  = 4;
  localparam int CTRL_DUP_BIT  = 5;

  localparam int ST_LB_LSB   = 0;
  localparam int ST_ALN_BIT  = 3;
  localparam int ST_LOCK_BIT = 4;
  localparam int ST_ENC_BIT  = 5;
  localparam int ST_BSER_BIT = 6;

  localparam logic [7:0]    PAT_STEP      = 8'h02;
  localparam logic [15:0]   ERR_MAX       = 16'hFFFF;
  localparam logic [DW-1:0] ALIGN_RST     = 20'h0_0000;

  typedef enum logic [1:0] {
    TLBC_FM_BASIC,
    TLBC_FM_PCIE,
    TLBC_FM_OTHER
  } tlbc_fmode_t;

  typedef enum logic [1:0] {
    TLBC_SUB_NONE,
    TLBC_SUB_BIST,
    TLBC_SUB_REVS,
    TLBC_SUB_PRECDR
  } tlbc_sub_t;

  typedef enum logic [2:0] {
    TLBC_LB_NONE,
    TLBC_LB_SER,
    TLBC_LB_PAR,
    TLBC_LB_REVS,
    TLBC_LB_PRECDR,
    TLBC_LB_PCIE
  } tlbc_lb_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] sub;
    logic       dbl;
    logic       duplex;
  } tlbc_cfg_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } tlbc_bus_req_t;

  typedef struct packed {
    tlbc_cfg_t     cfg;
    logic [DW-1:0] align_pat;
    tlbc_lb_t      lb;
    logic [DW-1:0] tx_word;
    logic [DW-1:0] rx_word;
    logic [DW-1:0] cdr_word;
    logic [DW-1:0] rm_word;
    logic [DW-1:0] line_tx;
    logic [DW-1:0] fab_rx;
    logic          aligned;
    logic [7:0]    gen_cnt;
    logic [7:0]    exp_cnt;
    logic          lock;
    logic [15:0]   err_cnt;
    logic          err_pulse;
    logic          err_flag;
    logic [31:0]   rdata;
  } tlbc_state_t;

endpackage

// file: rtl/tlbc_top.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tlbc_top (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire tlbc_pkg::tlbc_bus_req_t bus_req,
  output logic [31:0]                 bus_rdata,
  input  wire logic                   serial_lpbk_en,
  input  wire logic                   detect_rx_lpbk,
  input  wire logic                   rx_digital_reset,
  input  wire logic [tlbc_pkg::DW-1:0] fab_tx_data,
  output logic [tlbc_pkg::DW-1:0]     fab_rx_data,
  input  wire logic [tlbc_pkg::DW-1:0] line_rx_data,
  output logic [tlbc_pkg::DW-1:0]     line_tx_data,
  output logic [2:0]                  lb_active,
  output logic                        bist_err
);
  import tlbc_pkg::*;

  tlbc_state_t q;
  tlbc_state_t d;

  tlbc_lb_t      lb_sel;
  logic [DW-1:0] rx_src;
  logic [DW-1:0] tx_src;
  logic [DW-1:0] line_src;
  logic [PW-1:0] pat_word;
  logic [PW-1:0] exp_word;
  logic          rx_clr;

  // Loopback selection is a strict priority chain so two paths can never be live together.
  always_comb begin
    lb_sel = TLBC_LB_NONE;
    if (q.cfg.mode == TLBC_FM_PCIE) begin
      if (detect_rx_lpbk) begin
        lb_sel = TLBC_LB_PCIE;
      end
    end else if (q.cfg.mode == TLBC_FM_BASIC && q.cfg.sub == TLBC_SUB_BIST) begin
      if (q.cfg.duplex) begin
        lb_sel = TLBC_LB_PAR;
      end
    end else if (q.cfg.mode == TLBC_FM_BASIC && q.cfg.sub == TLBC_SUB_REVS) begin
      lb_sel = TLBC_LB_REVS;
    end else if (q.cfg.mode == TLBC_FM_BASIC && q.cfg.sub == TLBC_SUB_PRECDR) begin
      lb_sel = TLBC_LB_PRECDR;
    end else if (serial_lpbk_en) begin
      lb_sel = TLBC_LB_SER;
    end
  end

  always_comb begin
    pat_word = {q.gen_cnt + 8'h01, q.gen_cnt};
    exp_word = {q.exp_cnt + 8'h01, q.exp_cnt};
    // Receiver state restarts when the path changes; the fabric reset covers the same window.
    rx_clr   = rx_digital_reset || (lb_sel != q.lb);
  end

  // Data steering between fabric, PCS and line.
  always_comb begin
    tx_src   = fab_tx_data;
    rx_src   = line_rx_data;
    line_src = q.tx_word;
    case (q.lb)
      TLBC_LB_NONE: begin
        tx_src   = fab_tx_data;
        rx_src   = line_rx_data;
        line_src = q.tx_word;
      end
      TLBC_LB_SER: begin
        rx_src   = q.tx_word;
        line_src = q.tx_word;
      end
      TLBC_LB_PAR: begin
        tx_src   = {{(DW-PW){1'b0}}, pat_word};
        rx_src   = q.tx_word;
        line_src = q.tx_word;
      end
      TLBC_LB_REVS: begin
        line_src = q.cdr_word;
      end
      TLBC_LB_PRECDR: begin
        line_src = line_rx_data;
      end
      TLBC_LB_PCIE: begin
        line_src = q.rm_word;
      end
      default: begin
        tx_src   = fab_tx_data;
        rx_src   = line_rx_data;
        line_src = q.tx_word;
      end
    endcase
  end

  always_comb begin
    d           = q;
    d.err_pulse = 1'b0;
    d.lb        = lb_sel;
    d.tx_word   = tx_src;
    d.rx_word   = rx_src;
    d.cdr_word  = line_rx_data;
    d.rm_word   = q.rx_word;
    d.line_tx   = line_src;
    // Test data goes out on the line but not to the fabric; the fabric sees idle zeros.
    if (q.lb == TLBC_LB_PAR) begin
      d.fab_rx = '0;
    end else begin
      d.fab_rx = q.rx_word;
    end

    if (rx_clr) begin
      d.aligned = 1'b0;
    end else if (q.rx_word == q.align_pat) begin
      d.aligned = 1'b1;
    end

    if (q.lb == TLBC_LB_PAR) begin
      d.gen_cnt = q.gen_cnt + PAT_STEP;
    end else begin
      d.gen_cnt = '0;
    end

    if (rx_clr || q.lb != TLBC_LB_PAR) begin
      d.exp_cnt = '0;
      d.lock    = 1'b0;
    end else if (q.rx_word[PW-1:0] == exp_word) begin
      d.exp_cnt = q.exp_cnt + PAT_STEP;
      d.lock    = 1'b1;
    end else begin
      // Resynchronise on the received word so one slip costs one error, not a burst.
      d.exp_cnt   = q.rx_word[7:0] + PAT_STEP;
      d.err_pulse = q.lock;
    end

    d.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        CTRL_OFS:   d.rdata = {26'h000_0000, q.cfg};
        ALIGN_OFS:  d.rdata = {12'h000, q.align_pat};
        STATUS_OFS: begin
          d.rdata[ST_LB_LSB +: 3] = q.lb;
          d.rdata[ST_ALN_BIT]     = q.aligned;
          d.rdata[ST_LOCK_BIT]    = q.lock;
          d.rdata[ST_ENC_BIT]     = (q.lb == TLBC_LB_PAR);
          d.rdata[ST_BSER_BIT]    = (q.lb == TLBC_LB_PAR) && !q.cfg.dbl;
        end
        ERRCNT_OFS: d.rdata = {16'h0000, q.err_cnt};
        default:    d.rdata = '0;
      endcase
    end

    if (bus_req.wr) begin
      case (bus_req.addr)
        CTRL_OFS: begin
          d.cfg.mode   = bus_req.wdata[CTRL_MODE_LSB +: 2];
          d.cfg.sub    = bus_req.wdata[CTRL_SUB_LSB +: 2];
          d.cfg.dbl    = bus_req.wdata[CTRL_DBL_BIT];
          d.cfg.duplex = bus_req.wdata[CTRL_DUP_BIT];
        end
        ALIGN_OFS: d.align_pat = bus_req.wdata[DW-1:0];
        default: begin
          d.cfg = q.cfg;
        end
      endcase
    end

    // A new error in the clearing cycle survives as a count of one.
    if (bus_req.wr && bus_req.addr == ERRCNT_OFS) begin
      d.err_cnt = {15'h0000, d.err_pulse};
    end else if (d.err_pulse && q.err_cnt != ERR_MAX) begin
      d.err_cnt = q.err_cnt + 16'h0001;
    end
    // The error level is registered so the output pin comes straight from a flop.
    d.err_flag = (d.err_cnt != 16'h0000);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q           <= '0;
      q.cfg.mode  <= TLBC_FM_BASIC;
      q.cfg.sub   <= TLBC_SUB_NONE;
      q.align_pat <= ALIGN_RST;
      q.lb        <= TLBC_LB_NONE;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    bus_rdata    = q.rdata;
    fab_rx_data  = q.fab_rx;
    line_tx_data = q.line_tx;
    lb_active    = q.lb;
    bist_err     = q.err_flag;
  end

endmodule
`default_nettype wire

// file: testbench/tlbc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tlbc_chk (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    rx_digital_reset,
  input wire logic [tlbc_pkg::DW-1:0] fab_tx_data,
  input wire logic [tlbc_pkg::DW-1:0] fab_rx_data,
  input wire logic [tlbc_pkg::DW-1:0] line_rx_data,
  input wire logic [tlbc_pkg::DW-1:0] line_tx_data,
  input wire logic [2:0]              lb_active
);
  import tlbc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Each antecedent waits out the pipeline refill after a path change.
  property p_nrm; (lb_active == 3'd0)[*4] |-> line_tx_data == $past(fab_tx_data, 2); endproperty
  property p_ser; (lb_active == 3'd1 && !rx_digital_reset)[*5] |-> fab_rx_data == $past(fab_tx_data, 3); endproperty
  property p_hide; (lb_active == 3'd2)[*2] |-> fab_rx_data == '0; endproperty
  property p_pat;
    (lb_active == 3'd2)[*3] |-> line_tx_data[19:16] == 4'h0 && line_tx_data[15:8] == line_tx_data[7:0] + 8'h01;
  endproperty
  property p_step; (lb_active == 3'd2)[*4] |-> line_tx_data[7:0] == $past(line_tx_data[7:0]) + 8'h02; endproperty
  property p_rev;
    (lb_active == 3'd3 && !rx_digital_reset)[*4] |->
      line_tx_data == $past(line_rx_data, 2) && fab_rx_data == $past(line_rx_data, 2);
  endproperty
  property p_pre; (lb_active == 3'd4)[*2] |-> line_tx_data == $past(line_rx_data); endproperty
  property p_pcie; (lb_active == 3'd5)[*5] |-> line_tx_data == $past(line_rx_data, 3); endproperty
  a_nrm: assert property (p_nrm) else $error("normal transmit path wrong");
  a_ser: assert property (p_ser) else $error("serial loop data wrong");
  a_hide: assert property (p_hide) else $error("test pattern seen by fabric");
  a_pat: assert property (p_pat) else $error("pattern word malformed");
  a_step: assert property (p_step) else $error("pattern does not count");
  a_rev: assert property (p_rev) else $error("reverse serial data wrong");
  a_pre: assert property (p_pre) else $error("pre recovery data wrong");
  a_pcie: assert property (p_pcie) else $error("reverse parallel data wrong");
  c_ser: cover property (lb_active == 3'd1);
  c_par: cover property (lb_active == 3'd2);
  c_pcie: cover property (lb_active == 3'd5);
endmodule
bind tlbc_top tlbc_chk tlbc_chk_inst (.ref_clk, .rst, .rx_digital_reset, .fab_tx_data, .fab_rx_data,
  .line_rx_data, .line_tx_data, .lb_active);
`default_nettype wire

// file: testbench/tlbc_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tlbc_line_partner (
  input wire logic                ref_clk,
  output logic [tlbc_pkg::DW-1:0] line_rx_data
);
  import tlbc_pkg::*;
  // A fresh word every cycle, so a stuck or stale return path cannot match.
  initial line_rx_data = 20'h0_0001;
  always @(posedge ref_clk) line_rx_data <= line_rx_data + 20'h1_3579;
endmodule
`default_nettype wire

// file: testbench/tlbc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tlbc_top_tb;
  import tlbc_pkg::*;
  logic ref_clk, rst, ser_en, det, rxrst, fix, err, isb;
  tlbc_bus_req_t req;
  logic [31:0] rdata, d;
  logic [DW-1:0] ftx, frx, lrx, ltx;
  logic [2:0] lb;
  logic [12:0] e;
  int n_mismatch, tests_run;
  // Entry is control byte, serial enable, detect request, expected path.
  logic [12:0] tbl [11] = '{13'h0011, 13'h0030, 13'h003D, 13'h0482, 13'h0080, 13'h0682,
                            13'h0113, 13'h0184, 13'h01C0, 13'h0051, 13'h0000};
  tlbc_top tlbc_top_inst (.ref_clk, .rst, .bus_req(req), .bus_rdata(rdata), .serial_lpbk_en(ser_en),
    .detect_rx_lpbk(det), .rx_digital_reset(rxrst), .fab_tx_data(ftx), .fab_rx_data(frx),
    .line_rx_data(lrx), .line_tx_data(ltx), .lb_active(lb), .bist_err(err));
  tlbc_line_partner tlbc_line_partner_inst (.ref_clk, .line_rx_data(lrx));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) ftx <= fix ? 20'hA_5A3C : ftx + 20'h0_0101;
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk) req <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk) req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic enter(logic s, logic t);
    ser_en <= s;
    det <= t;
    rxrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rxrst <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    req = '0; ser_en = 0; det = 0; rxrst = 0; fix = 0; ftx = '0; rst = 1;
    n_mismatch = 0; tests_run = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h10);
    chk("unmapped", d, 32'h0);
    foreach (tbl[i]) begin
      e = tbl[i];
      wr(CTRL_OFS, {24'h00_0000, e[12:5]});
      enter(e[4], e[3]);
      isb = (e[2:0] == 3'd2);
      chk("path", {29'h0, lb}, {29'h0, e[2:0]});
      rd(STATUS_OFS);
      chk("status", {27'h0, d[6:5], d[2:0]}, {27'h0, isb & ~e[9], isb, e[2:0]});
      chk("bist_err", {31'h0, err}, 32'h0);
    end
    wr(ALIGN_OFS, 32'h000A_5A3C);
    fix <= 1'b1;
    enter(1'b1, 1'b0);
    rd(STATUS_OFS);
    chk("aligned", {31'h0, d[3]}, 32'h1);
    rd(ALIGN_OFS);
    chk("align", d, 32'h000A_5A3C);
    rd(ERRCNT_OFS);
    chk("errcnt", d, 32'h0000_0000);
    rd(CTRL_OFS);
    chk("ctrl", d, 32'h0000_0000);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
